// ===== hdl/sfrx_pkg.sv
// package for the serial frame receive channel control block
package sfrx_pkg;
  // ************************************************
  // register offsets (device numbers relative)
  // ************************************************
  localparam logic [3:0] OFF_DATA = 4'h0;
  localparam logic [3:0] OFF_FSTAT = 4'h2;
  localparam logic [3:0] OFF_TSTAT = 4'hA;
  localparam logic [3:0] OFF_ICW = 4'hB;
  // ************************************************
  // control word bits
  // ************************************************
  localparam int ICW_DAV_IE = 0;
  localparam int ICW_SAV_IE = 1;
  localparam int ICW_DMA_RQ = 3;
  localparam int ICW_DMA_IE = 4;
  localparam int ICW_LSC_IE = 7;
  // ************************************************
  // frame status fields
  // ************************************************
  localparam int FS_SOM = 0;
  localparam int FS_EOM = 1;
  localparam int FS_ABGA = 2;
  localparam int FS_OVR = 3;
  localparam int FS_ABC_LO = 4;
  localparam int FS_ERR = 7;
  localparam int IRQ_LEVEL = 13;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [2:0] ZERO3 = 3'h0;
  localparam logic [3:0] ZERO4 = 4'h0;
  // one character time in clocks when none is given by the line side
  localparam logic [15:0] CHAR_TIME_DEF = 16'h0100;

  // events from the protocol receiver
  typedef struct packed {
    logic charValid;   // one-cycle strobe, character assembled
    logic [7:0] charData;
    logic flagSeen;    // flag character
    logic abortSeen;
    logic goAheadSeen;
    logic closeFlag;   // closing flag after last char
    logic [2:0] bitCount;
    logic crcBad;
    logic lineChange;  // modem line change pulse
    logic [3:0] lineStat;
  } sfrx_line_s;

  // host access strobe
  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] addr;
    logic [15:0] wdata;
  } sfrx_bus_s;
endpackage

// ===== hdl/sfrx_char_timer.sv
// character-time counter used for overrun and start-of-message timeout
module sfrx_char_timer (
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic [15:0] period,
  output logic expire
);
  // ************************************************
  // state
  // ************************************************
  typedef struct packed {
    logic run;
    logic [15:0] cnt;
    logic exp;
  } sfrx_tmr_s;
  sfrx_tmr_s st_q, st_d;

  // count down from period, pulse at zero; restart wins
  always_comb begin
    st_d = st_q;
    st_d.exp = 1'b0;
    if (start) begin
      st_d.run = 1'b1;
      st_d.cnt = period;
    end else if (st_q.run) begin
      if (st_q.cnt == sfrx_pkg::ZERO16) begin
        st_d.run = 1'b0;
        st_d.exp = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt - 16'h0001;
      end
    end
  end

  // register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign expire = st_q.exp;
endmodule

// ===== hdl/sfrx_ctrl.sv
// receive channel control: routing, frame status, overrun, bit count
//
// Contract
// - receive interrupts go out on level 13
// - control word written at offset 11
// - data available while unread byte held
// - status available on frame status change
// - line change raises its own event
// - bit 3 routes data/status to DMA
// - DMA interrupt request gated by bit 4
// - line changes interrupt host when bit 7 set
// - transfer status at offset 10
// - frame status read clears status available
// - start bit and active on frame start
// - start bit self clears, no status event
// - end bit on close/abort/go-ahead
// - abort/go-ahead bit follows strip setting
// - abort character suppresses data available
// - overrun when unread one character time
// - bits 4-6 hold final bit count
// - zero count means boundary end
// - no address mode: activate on first char
// - error bit set on check mismatch
module sfrx_ctrl (
  input wire logic clk,
  input wire logic rstn,
  input sfrx_pkg::sfrx_bus_s bus,
  input sfrx_pkg::sfrx_line_s line,
  input wire logic dmaRead,
  input wire logic rxDmaIntReq,
  input wire logic receiverOn,
  input wire logic bitOrientedProtocol,
  input wire logic secondaryAddressMode,
  input wire logic stripSyncGoahead,
  input wire logic [7:0] stationAddress,
  input wire logic [15:0] charTime,
  output logic [15:0] rdata,
  output logic rdataValid,
  output logic hostIrq,
  output logic [3:0] hostIrqLevel,
  output logic receiveRequest,
  output logic rxActive,
  output logic rxDataAvailable,
  output logic rxStatusAvailable,
  output logic lineStatusChange
);
  // ************************************************
  // state
  // ************************************************
  typedef struct packed {
    logic [7:0] input_control_word;        // input control word
    logic [7:0] dataReg;    // receive data register
    logic dav;              // unread byte held
    logic sav;              // frame status changed
    logic lsc;              // line change pending
    logic som;
    logic eom;
    logic abga;
    logic ovr;
    logic [2:0] abc;
    logic err;
    logic inFrame;          // flag seen, waiting for first char
    logic active;           // receiver active
    logic [15:0] rdata;
    logic rdv;
    logic irq;
    logic receive_request;
  } sfrx_st_s;
  sfrx_st_s st_q, st_d;

  logic somStart;   // start of message this cycle
  logic ovrExpire;  // one character time passed
  logic datStart;   // new byte stored: arm overrun timer
  logic [15:0] tperiod;

  // fall back to a fixed character time if none supplied
  assign tperiod = (charTime == sfrx_pkg::ZERO16) ? sfrx_pkg::CHAR_TIME_DEF : charTime;

  // ************************************************
  // timers
  // ************************************************
  // one timer shared: start-of-message decay and overrun both use a character time
  sfrx_char_timer u_tmr (
    .clk(clk),
    .rstn(rstn),
    .start(somStart | datStart),
    .period(tperiod),
    .expire(ovrExpire)
  );

  // ************************************************
  // next state
  // ************************************************
  always_comb begin
    logic fsOld;
    logic [7:0] fsNow;
    logic rdData;
    logic rdFstat;
    logic addrOk;
    logic firstChar;
    logic endEvt;
    logic abEvt;
    fsOld = 1'b0;
    fsNow = sfrx_pkg::ZERO8;
    rdData = 1'b0;
    rdFstat = 1'b0;
    addrOk = 1'b0;
    firstChar = 1'b0;
    endEvt = 1'b0;
    abEvt = 1'b0;
    st_d = st_q;
    somStart = 1'b0;
    datStart = 1'b0;
    st_d.rdv = 1'b0;

    rdData = (bus.rd && bus.addr == sfrx_pkg::OFF_DATA) || dmaRead;
    rdFstat = bus.rd && bus.addr == sfrx_pkg::OFF_FSTAT;

    if (bus.wr && bus.addr == sfrx_pkg::OFF_ICW) begin
      st_d.input_control_word = bus.wdata[7:0];
    end

    // read mux, registered
    if (bus.rd) begin
      st_d.rdv = 1'b1;
      case (bus.addr)
        sfrx_pkg::OFF_DATA: st_d.rdata = {sfrx_pkg::ZERO8, st_q.dataReg};
        sfrx_pkg::OFF_FSTAT: st_d.rdata = {sfrx_pkg::ZERO8, st_q.err, st_q.abc, st_q.ovr,
                                           st_q.abga, st_q.eom, st_q.som};
        // line status, control readback, single lines
        sfrx_pkg::OFF_TSTAT: st_d.rdata = {line.lineStat, st_q.active, st_q.lsc, st_q.sav,
                                           st_q.dav, st_q.input_control_word};
        default: st_d.rdata = sfrx_pkg::ZERO16;
      endcase
    end

    // reads clear status; events below win over the clear
    if (rdFstat) begin
      st_d.sav = 1'b0;
      st_d.eom = 1'b0;
      st_d.abga = 1'b0;
      st_d.ovr = 1'b0;
      st_d.abc = sfrx_pkg::ZERO3;
      st_d.err = 1'b0;
    end
    if (rdData) begin
      st_d.dav = 1'b0;
    end
    if (bus.rd && bus.addr == sfrx_pkg::OFF_TSTAT) begin
      st_d.lsc = 1'b0;
    end

    // start bit decays after one character time, no status event
    if (ovrExpire && st_q.som) begin
      st_d.som = 1'b0;
    end

    // byte unread one character time later
    if (ovrExpire && st_q.dav && !rdData) begin
      st_d.ovr = 1'b1;
    end

    if (receiverOn && bitOrientedProtocol) begin
      if (line.flagSeen && !st_q.active) begin
        st_d.inFrame = 1'b1;
      end
      // abort or go-ahead per strip setting
      abEvt = stripSyncGoahead ? line.goAheadSeen : line.abortSeen;
      endEvt = (line.closeFlag && st_q.active) || line.abortSeen || line.goAheadSeen;
      if (abEvt) begin
        st_d.abga = 1'b1;
      end
      if (endEvt) begin
        st_d.eom = 1'b1;
        // final character bit count on close or go-ahead; zero on abort
        st_d.abc = line.goAheadSeen || line.closeFlag ? line.bitCount : sfrx_pkg::ZERO3;
        // check sequence result at frame end
        st_d.err = line.closeFlag && line.crcBad;
        st_d.active = 1'b0;
        st_d.inFrame = 1'b0;
      end
      firstChar = line.charValid && st_q.inFrame && !st_q.active;
      // without address mode any first char matches
      addrOk = !secondaryAddressMode || line.charData == stationAddress;
      if (firstChar) begin
        st_d.inFrame = 1'b0;
        if (addrOk) begin
          st_d.som = 1'b1;
          st_d.active = 1'b1;
          somStart = 1'b1;
        end
      end
    end else if (receiverOn) begin
      st_d.active = line.charValid ? 1'b1 : st_q.active;
    end

    // store a byte; abort char is never offered
    if (receiverOn && line.charValid && !line.abortSeen && (st_q.active || firstChar && addrOk)) begin
      if (st_q.ovr || (st_q.dav && !rdData)) begin
        st_d.ovr = 1'b1;
      end else begin
        st_d.dataReg = line.charData;
        st_d.dav = 1'b1;
        datStart = !somStart;
      end
    end

    // receiver disable clears frame status
    if (!receiverOn) begin
      st_d.som = 1'b0;
      st_d.eom = 1'b0;
      st_d.abga = 1'b0;
      st_d.ovr = 1'b0;
      st_d.abc = sfrx_pkg::ZERO3;
      st_d.err = 1'b0;
      st_d.active = 1'b0;
      st_d.inFrame = 1'b0;
    end

    // any change in frame status other than start bit raises status available, unless the new status is all zero
    fsNow = {st_d.err, st_d.abc, st_d.ovr, st_d.abga, st_d.eom, 1'b0};
    fsOld = fsNow != {st_q.err, st_q.abc, st_q.ovr, st_q.abga, st_q.eom, 1'b0};
    if (fsOld && (fsNow != sfrx_pkg::ZERO8)) begin
      st_d.sav = 1'b1;
    end

    // line change event, set wins over read clear
    if (line.lineChange) begin
      st_d.lsc = 1'b1;
    end

    // bit 3 routes data/status to DMA as a request
    st_d.receive_request = st_q.input_control_word[sfrx_pkg::ICW_DMA_RQ] && (st_d.dav || st_d.sav);
    // DMA interrupt request gated by bit 4
    // line change interrupts whatever the DMA routing
    st_d.irq = (st_q.input_control_word[sfrx_pkg::ICW_DAV_IE] && st_d.dav)
             || (st_q.input_control_word[sfrx_pkg::ICW_SAV_IE] && st_d.sav)
             || (st_q.input_control_word[sfrx_pkg::ICW_DMA_IE] && rxDmaIntReq)
             || (st_q.input_control_word[sfrx_pkg::ICW_LSC_IE] && st_d.lsc);
  end

  // ************************************************
  // registers
  // ************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
      hostIrqLevel <= sfrx_pkg::ZERO4;
    end else begin
      st_q <= st_d;
      hostIrqLevel <= 4'(sfrx_pkg::IRQ_LEVEL);
    end
  end

  // outputs straight from flops
  assign rdata = st_q.rdata;
  assign rdataValid = st_q.rdv;
  assign hostIrq = st_q.irq;
  assign receiveRequest = st_q.receive_request;
  assign rxActive = st_q.active;
  assign rxDataAvailable = st_q.dav;
  assign rxStatusAvailable = st_q.sav;
  assign lineStatusChange = st_q.lsc;
endmodule

// ===== tb/sfrx_ctrl_assertions.sv
// port checker for the receive channel control block
module sfrx_ctrl_checker (
  input wire logic clk,
  input wire logic rstn,
  input sfrx_pkg::sfrx_bus_s bus,
  input sfrx_pkg::sfrx_line_s line,
  input wire logic dmaRead,
  input wire logic receiverOn,
  input wire logic bitOrientedProtocol,
  input wire logic rdataValid,
  input wire logic [3:0] hostIrqLevel,
  input wire logic rxActive,
  input wire logic rxDataAvailable,
  input wire logic rxStatusAvailable,
  input wire logic lineStatusChange
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // any line event that may set status in the same cycle
  logic newEv;
  assign newEv = line.charValid | line.closeFlag | line.abortSeen | line.goAheadSeen;
  a_irq_level_fixed: assert property ($past(rstn) |-> hostIrqLevel == 4'hD)
    else $error("interrupt level wrong");
  a_read_answer: assert property (bus.rd |=> rdataValid)
    else $error("read not answered");
  a_read_quiet: assert property (!bus.rd |=> !rdataValid)
    else $error("read answer without read");
  a_data_clear: assert property (rxDataAvailable && dmaRead && !line.charValid |=> !rxDataAvailable)
    else $error("data available kept after read");
  a_status_clear: assert property (bus.rd && bus.addr == sfrx_pkg::OFF_FSTAT && !rxDataAvailable && !newEv
    |=> !rxStatusAvailable)
    else $error("status available kept after read");
  a_line_event: assert property (line.lineChange |=> lineStatusChange)
    else $error("line change lost");
  a_abort_no_data: assert property (line.abortSeen && !rxDataAvailable
    |=> !rxDataAvailable)
    else $error("abort offered data");
  a_close_status: assert property (line.closeFlag && receiverOn && bitOrientedProtocol && rxActive
    |=> rxStatusAvailable)
    else $error("close without status");
  a_start_data: assert property ($rose(rxActive) |-> rxDataAvailable)
    else $error("active without data");
endmodule

bind sfrx_ctrl sfrx_ctrl_checker i_chk (.clk, .rstn, .bus, .line, .dmaRead, .receiverOn, .bitOrientedProtocol,
  .rdataValid,
  .hostIrqLevel, .rxActive, .rxDataAvailable, .rxStatusAvailable, .lineStatusChange);

// ===== tb/sfrx_dma_model.sv
// behavioural dma processor serving the receive channel
module sfrx_dma_model (
  input wire logic clk,
  input wire logic enable,
  input wire logic [3:0] lag,
  input wire logic receiveRequest,
  output logic dmaRead,
  output logic rxDmaIntReq
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    dmaRead = 0;
    rxDmaIntReq = 0;
  end
  // serve a request by a data read after lag cycles
  always @(posedge clk) begin
    if (enable && receiveRequest) begin
      repeat (lag) @(posedge clk);
      #2 dmaRead = 1;
      @(posedge clk);
      #2 dmaRead = 0;
      // report the finished transfer to the host
      rxDmaIntReq = 1;
      @(posedge clk);
    end
    if (!enable) rxDmaIntReq = 0;
  end
endmodule

// ===== tb/testbench.sv
// self-checking bench for the receive channel control block
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rstn = 0, dmaOn = 0, receiverOn = 1, bit_oriented_protocol = 1, secondary_address_mode = 0, ssga = 0;
  logic dmaRead, rxDmaIntReq, rdataValid, hostIrq, receiveRequest, rxActive, dav, sav, lsc;
  logic [15:0] rdata, v;
  logic [3:0] hostIrqLevel;
  sfrx_pkg::sfrx_bus_s bus = '0;
  sfrx_pkg::sfrx_line_s line = '0, e = '0;
  int failures = 0, total_checks = 0, cyc = 0;
  always #12.5 clk = ~clk;
  sfrx_ctrl i_dut (.clk, .rstn, .bus, .line, .dmaRead, .rxDmaIntReq, .receiverOn,
    .bitOrientedProtocol(bit_oriented_protocol), .secondaryAddressMode(secondary_address_mode), .stripSyncGoahead(ssga),
    .stationAddress(8'h5A), .charTime(16'h0010), .rdata, .rdataValid, .hostIrq, .hostIrqLevel,
    .receiveRequest, .rxActive, .rxDataAvailable(dav), .rxStatusAvailable(sav), .lineStatusChange(lsc));
  sfrx_dma_model i_dma (.clk, .enable(dmaOn), .lag(4'h3), .receiveRequest, .dmaRead, .rxDmaIntReq);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic tick();
    @(posedge clk);
    #2;
  endtask
  task automatic rc(input logic [3:0] a, input logic [15:0] x);
    bus.rd = 1;
    bus.addr = a;
    tick();
    bus.rd = 0;
    chk(rdata, x);
    chk(16'(rdataValid), 16'h0001);
    // gap cycle so a following read raises its strobe on a fresh edge
    tick();
  endtask
  task automatic wr(input logic [15:0] d);
    bus.wr = 1;
    bus.addr = sfrx_pkg::OFF_ICW;
    bus.wdata = d;
    tick();
    bus.wr = 0;
  endtask
  task automatic ev();
    line = e;
    tick();
    line = '0;
    e = '0;
    // gap cycle so a following event strobe starts on a fresh edge
    tick();
  endtask
  task automatic chr(input logic [7:0] d);
    e.flagSeen = 1;
    ev();
    e.charValid = 1;
    e.charData = d;
    ev();
  endtask
  task automatic t_reset();
    chk(16'(hostIrqLevel), 16'h000D);
    rc(sfrx_pkg::OFF_FSTAT, 16'h0000);
    rc(4'h7, 16'h0000);
    $display("reset test done");
  endtask
  task automatic t_frame();
    // no dma, bits 3 and 4 cleared
    // no dma, bits 0, 1 and 7 set
    wr(16'h0083);
    chr(8'h3C);
    repeat (2) tick();
    chk({13'h0000, rxActive, dav, hostIrq}, 16'h0007);
    chk(16'(sav), 16'h0000);
    rc(sfrx_pkg::OFF_FSTAT, 16'h0001);
    rc(sfrx_pkg::OFF_DATA, 16'h003C);
    tick();
    chk(16'(dav), 16'h0000);
    repeat (20) tick();
    e.closeFlag = 1;
    e.bitCount = 3'h3;
    e.crcBad = 1;
    ev();
    tick();
    chk(16'(sav), 16'h0001);
    // software reads the error bit once the frame has ended
    rc(sfrx_pkg::OFF_FSTAT, 16'h00B2);
    rc(sfrx_pkg::OFF_FSTAT, 16'h0000);
    $display("frame test done");
  endtask
  task automatic t_abort();
    for (int g = 0; g < 2; g++) begin
      ssga = g[0];
      chr(8'h11);
      rc(sfrx_pkg::OFF_DATA, 16'h0011);
      repeat (20) tick();
      e.abortSeen = !g[0];
      e.charValid = !g[0];
      e.charData = 8'h7F;
      e.goAheadSeen = g[0];
      e.bitCount = 3'h5;
      ev();
      tick();
      chk(16'(dav), 16'h0000);
      rc(sfrx_pkg::OFF_FSTAT, g[0] ? 16'h0056 : 16'h0006);
    end
    $display("abort test done");
  endtask
  task automatic t_overrun();
    receiverOn = 0;
    repeat (2) tick();
    receiverOn = 1;
    secondary_address_mode = 1;
    chr(8'h22);
    tick();
    chk(16'(rxActive), 16'h0000);
    chr(8'h5A);
    repeat (20) tick();
    chk(16'(sav), 16'h0001);
    rc(sfrx_pkg::OFF_FSTAT, 16'h0008);
    e.charValid = 1;
    e.charData = 8'h77;
    ev();
    rc(sfrx_pkg::OFF_DATA, 16'h005A);
    rc(sfrx_pkg::OFF_FSTAT, 16'h0008);
    secondary_address_mode = 0;
    $display("overrun test done");
  endtask
  task automatic t_dma();
    wr(16'h0098);
    dmaOn = 1;
    chr(8'h44);
    chk(16'(receiveRequest), 16'h0001);
    for (int i = 0; i < 20 && !rxDmaIntReq; i++) tick();
    chk(16'(dav), 16'h0000);
    repeat (2) tick();
    chk(16'(hostIrq), 16'h0001);
    wr(16'h0088);
    repeat (2) tick();
    chk(16'(hostIrq), 16'h0000);
    e.lineChange = 1;
    ev();
    tick();
    chk(16'(hostIrq), 16'h0001);
    chk(16'(lsc), 16'h0001);
    bus.rd = 1;
    bus.addr = sfrx_pkg::OFF_TSTAT;
    tick();
    bus.rd = 0;
    chk(rdata & 16'h04FF, 16'h0488);
    dmaOn = 0;
    $display("dma test done");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    #2 rstn = 1;
    tick();
    t_reset();
    t_frame();
    t_abort();
    t_overrun();
    t_dma();
    close_out();
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      close_out();
    end
  end
endmodule
